// [port_pin_defs.vh]
`ifndef PORT_PIN_DEFS_VH
`define PORT_PIN_DEFS_VH
// Register byte addresses (printed offsets not all multiples of four: index * 4)
`define IDX_PULLUP 8'hec
`define IDX_EDGE 8'hee
`define IDX_IRQ_ENABLE 8'hed
`define IDX_P1_MODE 8'hf2
`define IDX_IRQ_STATUS 8'hf3
`define IDX_IRQ_CLEAR 8'hf4
`define IDX_IRQ_MASK 8'hf5
`define IDX_P0_DATA_OUT 8'hf6
`define IDX_P1_DATA_OUT 8'hf7
`define IDX_PIN_STATE 8'hf8
`define ADDR_PULLUP 12'h3b0
`define ADDR_EDGE 12'h3b8
`define ADDR_IRQ_ENABLE 12'h3b4
`define ADDR_P1_MODE 12'h3c8
`define ADDR_IRQ_STATUS 12'h3cc
`define ADDR_IRQ_CLEAR 12'h3d0
`define ADDR_IRQ_MASK 12'h3d4
`define ADDR_P0_DATA_OUT 12'h3d8
`define ADDR_P1_DATA_OUT 12'h3dc
`define ADDR_PIN_STATE 12'h3e0
// Reset values
`define RST_NIBBLE 4'h0
`define RST_P1_MODE 8'h00
// Mode field encodings
`define MODE_INPUT 2'b00
`define MODE_PUSH_PULL 2'b01
`define MODE_OPEN_DRAIN 2'b10
`define MODE_ANALOG 2'b11
`endif

// [port_pin_pullup_edge_config.v]
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`include "port_pin_defs.vh"

// How it works
// [RL1] Pull-up bit one connects that pin's resistor
// [RL2] Upper nibble unused, reads zero, resets zero
// [RL3] Edge bit: zero falling, one rising
// [RL4] Two-bit mode per second-port pin; 00 input
// [RL5] 01 push-pull, 10 open-drain drives low only
// [RL6] 11 hands pin to converter, driver off
// [RL7] Interrupt raised only for enabled first-port pins
// [RL8] Synchronise pins, compare samples, one-cycle request
module port_pin_pullup_edge_config (
  // APB slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // First port pins
  input wire [3:0] first_port_in,
  output reg [3:0] first_port_out,
  output reg [3:0] first_port_oe,
  output reg [3:0] first_port_pullup,
  output reg [3:0] edge_request,
  // Second port pins
  input wire [3:0] second_port_in,
  output reg [3:0] second_port_out,
  output reg [3:0] second_port_oe,
  output reg [3:0] converter_input_select,
  // Interrupt
  output reg irq
);

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [3:0] port0_pullup_enable;
reg [3:0] port0_interrupt_edge_select;
reg [3:0] port0_interrupt_enable;
reg [7:0] port1_pin_mode_control;
reg [3:0] irq_status;
reg [3:0] irq_mask;
reg [3:0] p0_data_out;
reg [3:0] p1_data_out;
reg [3:0] p0_sync1;
reg [3:0] p0_sync2;
reg [3:0] p0_sync3;
reg [3:0] p1_sync1;
reg [3:0] p1_sync2;
reg [3:0] p1_sync3;
reg [3:0] p0_level;
reg [3:0] p1_level;
wire [3:0] next_edge;
reg [31:0] next_rdata;
reg next_err;
wire [3:0] next_status;
wire [3:0] next_second_out;
wire [3:0] next_second_oe;
wire [3:0] next_converter_select;
wire setup = psel & ~penable;
wire wr_take = psel & penable & pready & pwrite & ~pslverr;
wire [3:0] clr_mask;
// One write strobe per writable word; unmapped, status and pin-state writes raise none
wire wr_pullup;
wire wr_edge;
wire wr_irq_enable;
wire wr_p1_mode;
wire wr_irq_clear;
wire wr_irq_mask;
wire wr_p0_data_out;
wire wr_p1_data_out;

assign wr_pullup = wr_take & (paddr == `ADDR_PULLUP);
assign wr_edge = wr_take & (paddr == `ADDR_EDGE);
assign wr_irq_enable = wr_take & (paddr == `ADDR_IRQ_ENABLE);
assign wr_p1_mode = wr_take & (paddr == `ADDR_P1_MODE);
assign wr_irq_clear = wr_take & (paddr == `ADDR_IRQ_CLEAR);
assign wr_irq_mask = wr_take & (paddr == `ADDR_IRQ_MASK);
assign wr_p0_data_out = wr_take & (paddr == `ADDR_P0_DATA_OUT);
assign wr_p1_data_out = wr_take & (paddr == `ADDR_P1_DATA_OUT);
assign clr_mask = wr_irq_clear ? pwdata[3:0] : 4'h0;
// Set beats clear when both land in one cycle
assign next_status = (irq_status & ~clr_mask) | edge_request;

////////////////////////////////////////////////////////////////////////////////
// Bus decode: one wait-free access phase, unmapped addresses answer pslverr

always @* begin
  next_err = 1'b0;
  next_rdata = 32'h00000000;
  case (paddr)
    `ADDR_PULLUP: next_rdata = {28'h0000000, port0_pullup_enable}; // [RL2]
    `ADDR_EDGE: next_rdata = {28'h0000000, port0_interrupt_edge_select}; // [RL2]
    `ADDR_IRQ_ENABLE: next_rdata = {28'h0000000, port0_interrupt_enable};
    `ADDR_P1_MODE: next_rdata = {24'h000000, port1_pin_mode_control};
    `ADDR_IRQ_STATUS: next_rdata = {28'h0000000, irq_status};
    `ADDR_IRQ_CLEAR: next_rdata = 32'h00000000;
    `ADDR_IRQ_MASK: next_rdata = {28'h0000000, irq_mask};
    `ADDR_P0_DATA_OUT: next_rdata = {28'h0000000, p0_data_out};
    `ADDR_P1_DATA_OUT: next_rdata = {28'h0000000, p1_data_out};
    `ADDR_PIN_STATE: next_rdata = {24'h000000, p1_level, p0_level};
    default: next_err = 1'b1;
  endcase
end

// Every setup is answered in the next cycle: no wait states
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pready <= 1'b0;
  end else begin
    pready <= setup;
  end
end

// pslverr flags an unmapped word; the write is then ignored
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pslverr <= 1'b0;
  end else begin
    pslverr <= setup & next_err;
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    prdata <= 32'h00000000;
  end else begin
    prdata <= (setup && !pwrite) ? next_rdata : 32'h00000000;
  end
end

// Only the low nibble is stored; upper bits of the word are dropped
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    port0_pullup_enable <= `RST_NIBBLE; // [RL2]
  end else if (wr_pullup) begin
    port0_pullup_enable <= pwdata[3:0]; // [RL1] [RL2]
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    port0_interrupt_edge_select <= `RST_NIBBLE; // [RL2]
  end else if (wr_edge) begin
    port0_interrupt_edge_select <= pwdata[3:0]; // [RL2] [RL3]
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    port0_interrupt_enable <= `RST_NIBBLE;
  end else if (wr_irq_enable) begin
    port0_interrupt_enable <= pwdata[3:0]; // [RL7]
  end
end

// Mode word is a full byte: four two-bit fields
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    port1_pin_mode_control <= `RST_P1_MODE;
  end else if (wr_p1_mode) begin
    port1_pin_mode_control <= pwdata[7:0]; // [RL4]
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    irq_mask <= `RST_NIBBLE;
  end else if (wr_irq_mask) begin
    irq_mask <= pwdata[3:0];
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    p0_data_out <= `RST_NIBBLE;
  end else if (wr_p0_data_out) begin
    p0_data_out <= pwdata[3:0];
  end
end

// Second-port data only reaches pins in the two output modes
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    p1_data_out <= `RST_NIBBLE;
  end else if (wr_p1_data_out) begin
    p1_data_out <= pwdata[3:0];
  end
end

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers; a level counts once stages two and three agree

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    p0_sync1 <= 4'h0;
    p0_sync2 <= 4'h0;
    p0_sync3 <= 4'h0;
    p0_level <= 4'h0;
  end else begin
    p0_sync1 <= first_port_in; // [RL8]
    p0_sync2 <= p0_sync1;
    p0_sync3 <= p0_sync2;
    p0_level <= (p0_sync2 & p0_sync3) | (p0_level & (p0_sync2 ^ p0_sync3));
  end
end

// Second-port levels only feed the pin-state register
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    p1_sync1 <= 4'h0;
    p1_sync2 <= 4'h0;
    p1_sync3 <= 4'h0;
    p1_level <= 4'h0;
  end else begin
    p1_sync1 <= second_port_in;
    p1_sync2 <= p1_sync1;
    p1_sync3 <= p1_sync2;
    p1_level <= (p1_sync2 & p1_sync3) | (p1_level & (p1_sync2 ^ p1_sync3));
  end
end

////////////////////////////////////////////////////////////////////////////////
// Per-pin edge detect for the first port

genvar i;
generate
  for (i = 0; i < 4; i = i + 1) begin : g_pin
    wire agreed = p0_sync2[i] & p0_sync3[i];
    wire agreed_low = ~p0_sync2[i] & ~p0_sync3[i];
    // Rising picks the low-to-high change, falling the reverse
    wire rise = agreed & ~p0_level[i];
    wire fall = agreed_low & p0_level[i];
    // Edge judged on the filtered level so a glitch of one sample is ignored
    assign next_edge[i] = port0_interrupt_edge_select[i] ? rise : fall; // [RL3] [RL8]
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Second-port mode decode, one copy per pin

generate
  for (i = 0; i < 4; i = i + 1) begin : g_mode
    wire [1:0] mode = port1_pin_mode_control[2*i +: 2]; // [RL4]
    wire is_push_pull = (mode == `MODE_PUSH_PULL);
    wire is_open_drain = (mode == `MODE_OPEN_DRAIN);
    wire is_analog = (mode == `MODE_ANALOG);
    // Input mode matches none of these, so the driver stays off
    assign next_second_out[i] = is_push_pull & p1_data_out[i]; // [RL4] [RL5]
    // Open drain only ever turns the driver on to pull low
    assign next_second_oe[i] = is_push_pull | (is_open_drain & ~p1_data_out[i]); // [RL5] [RL6]
    assign next_converter_select[i] = is_analog; // [RL6]
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Edge requests, sticky status and the interrupt line

// Masked per pin so a disabled pin never reaches status
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    edge_request <= 4'h0;
  end else begin
    edge_request <= next_edge & port0_interrupt_enable; // [RL7] [RL8]
  end
end

// Sticky until software writes a one to the clear word
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    irq_status <= 4'h0;
  end else begin
    irq_status <= next_status;
  end
end

// Registered from the next status so the line rises with the status bit
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    irq <= 1'b0;
  end else begin
    irq <= |(next_status & irq_mask); // [RL7]
  end
end

////////////////////////////////////////////////////////////////////////////////
// Pin drivers, all registered so no decode glitch reaches a pad

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    first_port_pullup <= 4'h0;
  end else begin
    first_port_pullup <= port0_pullup_enable; // [RL1]
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    first_port_out <= 4'h0;
  end else begin
    first_port_out <= p0_data_out;
  end
end

// First port is input only here; its driver is never enabled
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    first_port_oe <= 4'h0;
  end else begin
    first_port_oe <= 4'h0;
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    second_port_out <= 4'h0;
  end else begin
    second_port_out <= next_second_out; // [RL5]
  end
end

// Output enable high while the pin is driven
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    second_port_oe <= 4'h0;
  end else begin
    second_port_oe <= next_second_oe; // [RL5] [RL6]
  end
end

// Analogue mode also keeps the driver off, see the enable above
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    converter_input_select <= 4'h0;
  end else begin
    converter_input_select <= next_converter_select; // [RL6]
  end
end

endmodule // port_pin_pullup_edge_config

// [port_pin_checker_assertions.sv]
`timescale 1ns/100ps
`include "port_pin_defs.vh"
module port_pin_checker (
  input wire pclk, presetn, psel, penable, pwrite, pready,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire [3:0] first_port_in, first_port_pullup, edge_request,
  input wire [3:0] second_port_out, second_port_oe, converter_input_select
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc; psel && penable && pready; endsequence
  sequence s_mode; s_acc ##0 pwrite && paddr == `ADDR_P1_MODE; endsequence
  // Outputs may be registered after the register itself, so allow two edges
  property p_pull; s_acc ##0 pwrite && paddr == `ADDR_PULLUP ##2 1
    |-> first_port_pullup == $past(pwdata[3:0], 2); endproperty
  property p_rdz; s_acc ##0 !pwrite && (paddr == `ADDR_PULLUP || paddr == `ADDR_EDGE)
    |-> prdata[31:4] == 28'h0; endproperty
  property p_in; s_mode ##0 pwdata[1:0] == 2'b00 |-> ##2 !second_port_oe[0]; endproperty
  property p_pp; s_mode ##0 pwdata[1:0] == 2'b01 |-> ##2 second_port_oe[0]; endproperty
  property p_od; s_mode ##0 pwdata[1:0] == 2'b10 |-> ##2 !second_port_out[0]; endproperty
  property p_ana; (converter_input_select & second_port_oe) == 4'h0; endproperty
  property p_pulse; |edge_request |=> (edge_request & $past(edge_request)) == 4'h0; endproperty
  property p_sync; edge_request[0]
    |-> $past(first_port_in[0], 2) != $past(first_port_in[0], 7); endproperty
  a_pull: assert property (p_pull) else $error("pull-up pins differ from write");
  a_rdz: assert property (p_rdz) else $error("upper bits read nonzero");
  a_in: assert property (p_in) else $error("input mode drives pin");
  a_pp: assert property (p_pp) else $error("push-pull not driving");
  a_od: assert property (p_od) else $error("open drain drives high");
  a_ana: assert property (p_ana) else $error("analogue pin driven");
  a_pulse: assert property (p_pulse) else $error("request longer than a cycle");
  a_sync: assert property (p_sync) else $error("request without pin change");
endmodule // port_pin_checker
bind port_pin_pullup_edge_config port_pin_checker chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .first_port_in(first_port_in),
  .first_port_pullup(first_port_pullup), .edge_request(edge_request),
  .second_port_out(second_port_out), .second_port_oe(second_port_oe),
  .converter_input_select(converter_input_select));

// [tb.sv]
`timescale 1ns/100ps
`include "port_pin_defs.vh"
module tb;
  reg pclk, presetn, psel, penable, pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  reg [3:0] first_port_in, second_port_in;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  wire [3:0] fo, foe, pull, req, so, soe, sel;
  int n_errors = 0;
  int cmp_count = 0;
  logic [31:0] q;
  logic e;
  port_pin_pullup_edge_config dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_port_in(first_port_in), .first_port_out(fo),
    .first_port_oe(foe), .first_port_pullup(pull), .edge_request(req),
    .second_port_in(second_port_in), .second_port_out(so), .second_port_oe(soe),
    .converter_input_select(sel), .irq(irq));
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  // Bounded wait: a slave that never answers ends the run
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      end_of_test;
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk(q, exp, "read data");
  endtask
  task wait_req(input logic exp);
    logic got;
    got = 0;
    repeat (12) @(posedge pclk) if (req[0] === 1'b1) got = 1;
    chk(got, exp, "edge request");
  endtask
  //////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(`ADDR_PULLUP, 0);
    rd(`ADDR_EDGE, 0);
    rd(`ADDR_P1_MODE, 0);
    apb(0, 12'hffc, 0);
    chk(e, 1, "unmapped error");
    apb(1, `ADDR_PULLUP, 32'hffffffff);
    rd(`ADDR_PULLUP, 32'hf);
    chk(pull, 4'hf, "pull-up pins");
    apb(1, `ADDR_PULLUP, 32'h5);
    @(posedge pclk);
    chk(pull, 4'h5, "pull-up pins");
    apb(1, `ADDR_P0_DATA_OUT, 32'h6);
    @(posedge pclk);
    chk({foe, fo}, 8'h06, "first port drive");
    $display("registers done");
  endtask
  task t_modes;
    logic [11:0] tbl [4];
    tbl = '{12'h000, 12'h0fa, 12'h050, 12'hf00};
    second_port_in <= 4'h9;
    apb(1, `ADDR_P1_DATA_OUT, 32'ha);
    for (int m = 0; m < 4; m++) begin
      apb(1, `ADDR_P1_MODE, {24'h0, {4{m[1:0]}}});
      @(posedge pclk);
      chk({sel, soe, so & soe}, tbl[m], "pin mode");
    end
    apb(1, `ADDR_P1_MODE, 0);
    rd(`ADDR_PIN_STATE, 32'h90);
    $display("modes done");
  endtask
  task t_reset;
    apb(1, `ADDR_P1_MODE, 32'hff);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk({sel, soe, pull}, 0, "outputs after reset");
    rd(`ADDR_P1_MODE, 0);
    rd(`ADDR_PULLUP, 0);
    $display("reset done");
  endtask
  task t_irq;
    apb(1, `ADDR_IRQ_ENABLE, 32'h1);
    apb(1, `ADDR_IRQ_MASK, 32'h1);
    apb(1, `ADDR_EDGE, 32'h1);
    first_port_in <= 4'h1;
    wait_req(1);
    chk(irq, 1, "irq raised");
    rd(`ADDR_IRQ_STATUS, 1);
    apb(1, `ADDR_IRQ_CLEAR, 32'h1);
    @(posedge pclk);
    chk(irq, 0, "irq cleared");
    first_port_in <= 4'h0;
    wait_req(0);
    apb(1, `ADDR_EDGE, 32'h0);
    first_port_in <= 4'h1;
    wait_req(0);
    first_port_in <= 4'h0;
    wait_req(1);
    apb(1, `ADDR_IRQ_ENABLE, 32'h0);
    first_port_in <= 4'h1;
    wait_req(0);
    first_port_in <= 4'h0;
    wait_req(0);
    $display("interrupts done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    first_port_in = 0;
    second_port_in = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs;
    t_modes;
    t_reset;
    t_irq;
    end_of_test;
  end
endmodule // tb
